// *** bench/aicsw_partner.sv ***
// init engine and save responder on the far side of the clock sequencer
module aicsw_partner #(
  parameter int INIT_CYC = 20
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic save_active,
  output logic      init_done,
  output logic      save_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_ff;
  logic [1:0] div_ff;
  logic       init_tick;
  // init engine and config port run on a quarter-rate init clock, 5 MHz
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
  assign init_tick = (div_ff == 2'h3);
  // init completes a while after reset; save ends a few cycles into the window
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff    <= 8'h00;
      init_done <= 1'h0;
      save_done <= 1'h0;
    end else begin
      cnt_ff    <= (!init_done || save_active) ? cnt_ff + 8'h01 : 8'h00;
      init_done <= init_done | (init_tick && cnt_ff >= 8'(INIT_CYC));
      if (init_tick) begin
        // config mux touched only inside the init-clock save window
        save_done <= init_done & save_active & (cnt_ff > 8'h05);
      end
    end
  end
endmodule // aicsw_partner

// *** bench/test_analog_init_clock_switching.sv ***
// self-checking bench for the analog init clock switching core
module test_analog_init_clock_switching
  import aicsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, init_done, save_req, save_done, rtc_used, rtc_mode_req;
  logic init_grant, user_grant, clk_sel, save_active, adc_tick;
  logic osc_source_select, osc_mode_control;
  logic [ADC_DIV_W-1:0] adc_div_req, adc_div;
  aicsw_nvm_cmd_type    init_cmd, user_cmd, nvm_cmd;
  int                   miscompares, n_checks;

  aicsw_core i_dut (.core_clk(core_clk), .rstn(rstn), .init_done(init_done),
    .save_req(save_req), .save_done(save_done), .rtc_used(rtc_used),
    .rtc_mode_req(rtc_mode_req), .adc_div_req(adc_div_req), .init_cmd(init_cmd),
    .user_cmd(user_cmd), .init_grant(init_grant), .user_grant(user_grant),
    .nvm_cmd(nvm_cmd), .clk_sel(clk_sel), .save_active(save_active),
    .adc_div(adc_div), .adc_tick(adc_tick), .osc_source_select(osc_source_select),
    .osc_mode_control(osc_mode_control));
  aicsw_partner i_partner (.core_clk(core_clk), .rstn(rstn),
    .save_active(save_active), .init_done(init_done), .save_done(save_done));

  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // slow clock until init completes, then fast
  task automatic t_init_switch();
    int n = 0;
    while (n < 40 && init_done !== 1'h1) begin
      @(posedge core_clk);
      #1;
      check(clk_sel, SEL_INIT_CLOCK);
      n++;
    end
    @(posedge core_clk);
    #1;
    check(clk_sel, SEL_INIT_CLOCK);
    repeat (4) @(posedge core_clk);
    #1;
    check(clk_sel, SEL_FAST_CLOCK);
    // select must hold once switched, no bounce back
    repeat (4) @(posedge core_clk);
    #1;
    check(clk_sel, SEL_FAST_CLOCK);
  endtask

  // both ask: init engine wins, then user gets through
  task automatic t_arbiter();
    aicsw_nvm_cmd_type a = '{1'h1, 1'h1, 16'h0040, 32'h0000_a5a5};
    aicsw_nvm_cmd_type b = '{1'h1, 1'h0, 16'h0081, 32'h1234_5678};
    @(posedge core_clk);
    init_cmd <= a;
    user_cmd <= b;
    @(posedge core_clk);
    #1;
    check({init_grant, user_grant}, 2'h2);
    check(nvm_cmd, a);
    @(posedge core_clk);
    init_cmd <= NVM_CMD_RESET;
    @(posedge core_clk);
    #1;
    check({init_grant, user_grant}, 2'h1);
    check(nvm_cmd, b);
    @(posedge core_clk);
    user_cmd <= NVM_CMD_RESET;
  endtask

  // divider codes snap to multiples of four, tick period follows
  task automatic t_adc();
    logic [ADC_DIV_W-1:0] req [5] = '{6'h00, 6'h02, 6'h04, 6'h0d, 6'h08};
    logic [ADC_DIV_W-1:0] want [5] = '{6'h00, 6'h00, 6'h04, 6'h0c, 6'h08};
    int n = 0;
    foreach (req[i]) begin
      @(posedge core_clk);
      adc_div_req <= req[i];
      @(posedge core_clk);
      #1;
      check(adc_div, want[i]);
    end
    // line up on the first tick of the new divider, then count 32 cycles
    while (n < 20 && adc_tick !== 1'h1) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(adc_tick, 1'h1);
    n = 0;
    repeat (32) begin
      @(posedge core_clk);
      #1;
      n += (adc_tick === 1'h1);
    end
    check(n, 4);
  endtask

  // save window runs on the init clock, then back to fast
  task automatic t_save();
    int n = 0;
    @(posedge core_clk);
    save_req <= 1'h1;
    @(posedge core_clk);
    save_req <= 1'h0;
    #1;
    check({save_active, clk_sel}, {1'h1, SEL_INIT_CLOCK});
    while (n < 30 && save_active !== 1'h0) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({save_active, clk_sel}, {1'h0, SEL_FAST_CLOCK});
  endtask

  // oscillator source and mode controls
  task automatic t_osc();
    @(posedge core_clk);
    rtc_used     <= 1'h1;
    rtc_mode_req <= 1'h1;
    repeat (4) @(posedge core_clk);
    #1;
    check({osc_source_select, osc_mode_control}, 2'h3);
    @(posedge core_clk);
    rtc_mode_req <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    check({osc_source_select, osc_mode_control}, 2'h2);
  endtask

  // 20 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  // watchdog
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end

  // reset, then the scenarios in turn
  initial begin
    rstn = 1'h0;
    save_req = 1'h0;
    rtc_used = 1'h0;
    rtc_mode_req = 1'h0;
    adc_div_req = 6'h00;
    init_cmd = NVM_CMD_RESET;
    user_cmd = NVM_CMD_RESET;
    repeat (8) @(posedge core_clk);
    rstn <= 1'h1;
    t_init_switch();
    t_arbiter();
    t_adc();
    t_save();
    t_osc();
    report_and_stop();
  end
endmodule // test_analog_init_clock_switching

// *** core/aicsw_adc_div.sv ***
// adc conversion clock enable divider
module aicsw_adc_div
  import aicsw_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic [ADC_DIV_W-1:0] div_code,
  output logic                      adc_tick
);

  logic [ADC_DIV_W-1:0] cnt_ff;
  logic [ADC_DIV_W-1:0] div_last_ff;

  // counter restarts whenever the divider changes so no short period slips out
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff      <= ADC_DIV_RESET;
      div_last_ff <= ADC_DIV_RESET;
    end else begin
      div_last_ff <= div_code;
      if (div_code != div_last_ff || div_code == ADC_DIV_RESET) begin
        cnt_ff <= ADC_DIV_RESET;
      end else if (cnt_ff == div_code - 6'h01) begin
        cnt_ff <= ADC_DIV_RESET;
      end else begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  // one enable pulse per divided period; divider zero stops the adc clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      adc_tick <= 1'b0;
    end else begin
      adc_tick <= (div_code != ADC_DIV_RESET) && (div_code == div_last_ff)
                  && (cnt_ff == div_code - 6'h01);
    end
  end

endmodule // aicsw_adc_div

// *** core/aicsw_core.sv ***
// init/fast clock sequencing, nvm arbitration, adc divider and oscillator controls
// Summary of operation
// - adc divider only 0,4,8,12,16...
// - adc clock below 10 MHz, independent
// - init engine always wins nvm arbitration
// - init and saves run on init clock
// - drive oscillator source and mode controls
module aicsw_core
  import aicsw_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 init_done,
  input  wire logic                 save_req,
  input  wire logic                 save_done,
  input  wire logic                 rtc_used,
  input  wire logic                 rtc_mode_req,
  input  wire logic [ADC_DIV_W-1:0] adc_div_req,
  input  aicsw_nvm_cmd_type         init_cmd,
  input  aicsw_nvm_cmd_type         user_cmd,
  output logic                      init_grant,
  output logic                      user_grant,
  output aicsw_nvm_cmd_type         nvm_cmd,
  output logic                      clk_sel,
  output logic                      save_active,
  output logic [ADC_DIV_W-1:0]      adc_div,
  output logic                      adc_tick,
  output logic                      osc_source_select,
  output logic                      osc_mode_control
);

  logic [SYNC_W-1:0]    sync1_ff;
  logic [SYNC_W-1:0]    sync2_ff;
  aicsw_state_type      state_ff;
  aicsw_state_type      nxt_state;
  logic [ADC_DIV_W-1:0] nxt_adc_div;
  logic                 save_pend_ff;

  // two-stage synchronisers for the status levels that arrive from outside
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= SYNC_RESET;
      sync2_ff <= SYNC_RESET;
    end else begin
      sync1_ff <= {rtc_used, save_done, init_done};
      sync2_ff <= sync1_ff;
    end
  end

  // save request is remembered until the sequencer can take it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      save_pend_ff <= 1'b0;
    end else if (save_req) begin
      save_pend_ff <= 1'b1;  // set wins over clear
    end else if (state_ff == ST_SAVE) begin
      save_pend_ff <= 1'b0;
    end
  end

  // clock sequencing: init clock until init completes, back to it for each save
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_INIT: if (sync2_ff[SYNC_INIT_DONE]) nxt_state = ST_RUN;
      ST_RUN:  if (save_pend_ff || save_req) nxt_state = ST_SAVE;
      ST_SAVE: if (sync2_ff[SYNC_SAVE_DONE] && !save_req && !save_pend_ff) begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // select and save window registered so the downstream clock mux sees clean levels
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_sel     <= SEL_INIT_CLOCK;
      save_active <= 1'b0;
    end else begin
      clk_sel     <= (nxt_state == ST_RUN) ? SEL_FAST_CLOCK : SEL_INIT_CLOCK;
      save_active <= (nxt_state == ST_SAVE);
    end
  end

  // fixed priority: init engine first, user only when init is idle
  always_comb begin
    init_grant = init_cmd.valid;
    user_grant = user_cmd.valid && !init_cmd.valid;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nvm_cmd <= NVM_CMD_RESET;
    end else if (init_grant) begin
      nvm_cmd <= init_cmd;
    end else if (user_grant) begin
      nvm_cmd <= user_cmd;
    end else begin
      nvm_cmd <= NVM_CMD_RESET;
    end
  end

  // divider forced onto the step grid and clamped above the adc rate ceiling
  always_comb begin
    nxt_adc_div = {adc_div_req[ADC_DIV_W-1:2], ADC_DIV_LSB0};
    if (nxt_adc_div != ADC_DIV_RESET && nxt_adc_div < ADC_DIV_MIN) begin
      nxt_adc_div = ADC_DIV_MIN;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      adc_div <= ADC_DIV_RESET;
    end else begin
      adc_div <= nxt_adc_div;
    end
  end

  aicsw_adc_div u_adc_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .div_code (adc_div),
    .adc_tick (adc_tick)
  );

  // crystal oscillator steering while the real-time counter is in use
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_source_select <= 1'b0;
      osc_mode_control  <= 1'b0;
    end else begin
      osc_source_select <= sync2_ff[SYNC_RTC_USED];
      osc_mode_control  <= sync2_ff[SYNC_RTC_USED] && rtc_mode_req;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_adc_grid;
    adc_div[1:0] == ADC_DIV_LSB0;
  endproperty
  a_adc_grid: assert property (p_adc_grid) else $error("adc divider off grid");

  property p_adc_spacing;
    adc_tick |=> !adc_tick [*3];
  endproperty
  a_adc_spacing: assert property (p_adc_spacing) else $error("adc clock too fast");

  property p_init_first;
    init_cmd.valid |-> init_grant && !user_grant ##1 nvm_cmd == $past(init_cmd);
  endproperty
  a_init_first: assert property (p_init_first) else $error("init engine lost arbitration");

  property p_save_slow;
    state_ff == ST_RUN && save_req |=> ##1 clk_sel == SEL_INIT_CLOCK && save_active;
  endproperty
  a_save_slow: assert property (p_save_slow) else $error("save not on init clock");

  property p_init_slow;
    state_ff == ST_INIT && !sync2_ff[SYNC_INIT_DONE] |=> clk_sel == SEL_INIT_CLOCK;
  endproperty
  a_init_slow: assert property (p_init_slow) else $error("fast clock before init done");

  property p_osc_sel;
    sync2_ff[SYNC_RTC_USED] |=> osc_source_select;
  endproperty
  a_osc_sel: assert property (p_osc_sel) else $error("oscillator not steered");

  // mode control only ever rides on an active source select
  property p_osc_mode;
    osc_mode_control |-> osc_source_select;
  endproperty
  a_osc_mode: assert property (p_osc_mode) else $error("oscillator mode without source");

  // never both grants at once
  property p_grant_excl;
    !(init_grant && user_grant);
  endproperty
  a_grant_excl: assert property (p_grant_excl) else $error("both nvm grants high");

  // user request passes to the memory once the init engine is idle
  property p_user_pass;
    user_cmd.valid && !init_cmd.valid |=> nvm_cmd == $past(user_cmd);
  endproperty
  a_user_pass: assert property (p_user_pass) else $error("user request not forwarded");

  // the save window always sits on the init clock
  property p_save_window;
    save_active |-> clk_sel == SEL_INIT_CLOCK;
  endproperty
  a_save_window: assert property (p_save_window) else $error("save window on fast clock");

  // synced init complete moves the select to the fast clock at the next edge
  property p_fast_after_init;
    state_ff == ST_INIT && sync2_ff[SYNC_INIT_DONE] |=> clk_sel == SEL_FAST_CLOCK;
  endproperty
  a_fast_after_init: assert property (p_fast_after_init) else $error("no switch after init");

  // a running divider never drops below the rate floor
  property p_adc_floor;
    adc_div == ADC_DIV_RESET || adc_div >= ADC_DIV_MIN;
  endproperty
  a_adc_floor: assert property (p_adc_floor) else $error("adc divider below floor");

  // divider zero keeps the adc clock stopped
  property p_adc_stopped;
    adc_div == ADC_DIV_RESET |=> !adc_tick;
  endproperty
  a_adc_stopped: assert property (p_adc_stopped) else $error("adc tick while stopped");

  c_switch_fast: cover property (clk_sel == SEL_INIT_CLOCK ##1 clk_sel == SEL_FAST_CLOCK);
  c_save_cycle:  cover property (save_active ##[1:50] !save_active);
  c_contention:  cover property (init_cmd.valid && user_cmd.valid);
  c_adc_tick:    cover property (adc_tick);

endmodule // aicsw_core

// *** core/aicsw_pkg.sv ***
// constants, states and carriers shared by the analog init clock switching block
package aicsw_pkg;

  // clock rates
  localparam int unsigned CORE_CLK_HZ    = 20_000_000;  // core_clk rate
  localparam int unsigned ADC_CLK_MAX_HZ = 10_000_000;  // adc conversion clock ceiling
  localparam int unsigned ADC_DIV_STEP   = 4;           // divider granularity

  // smallest legal divider that keeps the adc clock strictly below its ceiling
  localparam int unsigned ADC_DIV_MIN_I =
    ((CORE_CLK_HZ / ADC_CLK_MAX_HZ) / ADC_DIV_STEP) * ADC_DIV_STEP + ADC_DIV_STEP;

  // widths
  localparam int unsigned ADC_DIV_W = 6;
  localparam int unsigned NVM_AW    = 16;
  localparam int unsigned NVM_DW    = 32;
  localparam int unsigned SYNC_W    = 3;

  localparam logic [ADC_DIV_W-1:0] ADC_DIV_MIN   = ADC_DIV_MIN_I[ADC_DIV_W-1:0];
  localparam logic [ADC_DIV_W-1:0] ADC_DIV_RESET = 6'h00;  // adc clock stopped
  localparam logic [1:0]           ADC_DIV_LSB0  = 2'h0;

  // clock select encoding
  localparam logic SEL_INIT_CLOCK = 1'b0;
  localparam logic SEL_FAST_CLOCK = 1'b1;

  // synchroniser bit positions
  localparam int unsigned SYNC_INIT_DONE = 0;
  localparam int unsigned SYNC_SAVE_DONE = 1;
  localparam int unsigned SYNC_RTC_USED  = 2;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h0;

  // clock sequencing states
  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN,
    ST_SAVE
  } aicsw_state_type;

  // one request to the nonvolatile memory
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [NVM_AW-1:0] addr;
    logic [NVM_DW-1:0] wdata;
  } aicsw_nvm_cmd_type;

  localparam aicsw_nvm_cmd_type NVM_CMD_RESET = '0;

endpackage : aicsw_pkg
